// ---- accel_power_regs.vh ----
// Purpose: constants for the power and operating-mode register bank
// Assumes: 8-bit registers on a 6-bit byte address, 125 MHz system clock
// Notes:   offsets are byte addresses of the register port
`ifndef ACCEL_POWER_REGS_VH
`define ACCEL_POWER_REGS_VH

`define ADDR_W                6
`define DATA_W                8

`define MOTION_CFG_OFFSET     6'h27
`define IRQ_MAP_ONE_OFFSET    6'h2a
`define IRQ_MAP_TWO_OFFSET    6'h2b
`define POWER_MODE_OFFSET     6'h2d
`define FORCE_CHECK_OFFSET    6'h2e

`define POWER_MODE_RESET      8'h00
`define FORCE_CHECK_RESET     8'h00
`define MOTION_CFG_RESET      8'h00
`define IRQ_MAP_RESET         8'h00
`define UNMAPPED_READ         8'h00

// power_mode_control fields
`define EXT_TIMEBASE_BIT      6
`define NOISE_HI              5
`define NOISE_LO              4
`define WATCH_BIT             3
`define AUTO_SLEEP_BIT        2
`define RUN_HI                1
`define RUN_LO                0
`define RUN_RUN_STATE_SELECT           2'h2
`define RUN_STANDBY           2'h0
`define NOISE_NORMAL          2'h0

// force_check_control fields
`define TEST_FORCE_BIT        0

// motion_detect_config link/loop field
`define LINK_LOOP_HI          5
`define LINK_LOOP_LO          4

// interrupt map fields
`define MAP_ACTIVE_LOW_BIT    7
`define MAP_AWAKE_BIT         6
`define MAP_INACT_BIT         5
`define MAP_ACT_BIT           4

// timing: internal oscillator tick period and wake-up mode rate divider
`define CLK_PERIOD_NS         8
`define INT_TICK_PERIOD_NS    1000
`define INT_TICK_CYCLES       (`INT_TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define WATCH_RATE_DIV        16

`endif

// ---- timebase_select.v ----
// Purpose: picks the block timebase from an internal divider or an outside clock pin
// Assumes: outside clock is much slower than CLK
// Notes:   pin passes three flops; a rising edge counts once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
`include "accel_power_regs.vh"

module timebase_select (
  input  wire clk,
  input  wire srst,
  input  wire ext_select,
  input  wire pin_in,
  output reg  tick
);

  reg        sync_a_reg;
  reg        sync_b_reg;
  reg        sync_c_reg;
  reg        level_reg;
  reg [15:0] div_reg;

  // last divider count, cut to the counter width on purpose
  localparam [31:0] TICK_LAST = `INT_TICK_CYCLES - 1;
  wire div_wrap = (div_reg == TICK_LAST[15:0]);

  always @(posedge clk) begin
    if (srst) begin
      sync_a_reg <= 1'b0;
      sync_b_reg <= 1'b0;
      sync_c_reg <= 1'b0;
      level_reg  <= 1'b0;
      div_reg    <= 16'h0000;
      tick       <= 1'b0;
    end else begin
      sync_a_reg <= pin_in;
      sync_b_reg <= sync_a_reg;
      sync_c_reg <= sync_b_reg;
      if (sync_b_reg == sync_c_reg) begin
        level_reg <= sync_c_reg;
      end
      div_reg <= div_wrap ? 16'h0000 : div_reg + 16'h0001;
      if (ext_select) begin
        // every timing tick follows the outside clock
        tick <= (sync_b_reg == sync_c_reg) && sync_c_reg && !level_reg;
      end else begin
        tick <= div_wrap;
      end
    end
  end

endmodule // timebase_select
`default_nettype wire

// ---- accel_power_mode_control.v ----
// Purpose: power and operating-mode register bank with awake state and pin drive
// Assumes: activity and inactivity pulses come from detector logic on CLK
// Notes:   register port answers reads one cycle later; never stalls
// Contract
// - external timebase bit 6 moves all timing to the clock on pin one
// - noise field [5:4]: 00 normal, 01 low, 10 ultralow, 11 reserved
// - wake-up bit 3 set runs the device at the low wake-up rate
// - auto sleep bit 2 ignored unless linked or loop motion detection
// - effective auto sleep enters wake-up mode on inactivity by itself
// - run field [1:0]: 00 standby, 10 measurement, others reserved
// - power control at 0x2D resets to 0x00: standby, normal, internal clock
// - self-test bit 0 applies test force to all three axes together
// - self-test register at 0x2E resets 0x00, bits [7:1] plain storage
// - awake state keeps driving mapped pin with no host traffic; pin one is released instead while external timebase bit 6 is set
// - map bit 6 routes awake to pin, bit 7 makes pin active low
`timescale 1ns/1ps
`default_nettype none
`include "accel_power_regs.vh"

module accel_power_mode_control (
  input  wire       CLK,
  input  wire       SRST,
  input  wire [5:0] ADDR,
  input  wire [7:0] WDATA,
  input  wire       WR,
  input  wire       RD,
  output reg  [7:0] RDATA,
  input  wire       ACTIVITY_EVENT,
  input  wire       INACTIVITY_EVENT,
  input  wire       IRQ_PIN_ONE_IN,
  output reg        IRQ_PIN_ONE_OUT,
  output reg        IRQ_PIN_ONE_OE,
  output reg        IRQ_PIN_TWO_OUT,
  output reg        IRQ_PIN_TWO_OE,
  output reg        SAMPLE_STROBE,
  output reg  [1:0] NOISE_MODE,
  output reg        RUN_ACTIVE,
  output reg        WATCH_ACTIVE,
  output reg        TEST_FORCE,
  output reg        AWAKE
);

  reg  [7:0] power_mode_control_reg;
  reg  [7:0] force_check_control_reg;
  reg  [7:0] motion_detect_config_reg;
  reg  [7:0] irq_map_one_reg;
  reg  [7:0] irq_map_two_reg;
  reg        awake_reg;
  reg        awake_next;
  reg  [4:0] watch_div_reg;
  reg  [7:0] read_next;
  wire       base_tick;

  // last wake-up divider count, cut to the counter width on purpose
  localparam [31:0] WATCH_LAST = `WATCH_RATE_DIV - 1;

  // pin level for one interrupt map: awake, inactivity, activity, polarity
  function pin_level;
    input [7:0] map;
    input       awake_state;
    input       inact;
    input       act;
    reg         any;
    begin
      any = (map[`MAP_AWAKE_BIT] & awake_state) |
            (map[`MAP_INACT_BIT] & inact) |
            (map[`MAP_ACT_BIT] & act);
      pin_level = map[`MAP_ACTIVE_LOW_BIT] ? ~any : any;
    end
  endfunction

  // a pin with nothing mapped is left undriven
  function pin_mapped;
    input [7:0] map;
    begin
      pin_mapped = |map[`MAP_AWAKE_BIT:`MAP_ACT_BIT];
    end
  endfunction

  wire measuring  = (power_mode_control_reg[`RUN_HI:`RUN_LO] == `RUN_RUN_STATE_SELECT);
  wire link_loop  = motion_detect_config_reg[`LINK_LOOP_LO];
  // auto sleep only counts in linked or loop detection
  wire sleep_eff  = power_mode_control_reg[`AUTO_SLEEP_BIT] & link_loop;
  // host-set wake-up bit, or auto sleep after inactivity
  wire watch_eff  = power_mode_control_reg[`WATCH_BIT] | (sleep_eff & ~awake_reg);
  wire ext_timing = power_mode_control_reg[`EXT_TIMEBASE_BIT];

  timebase_select u_timebase (
    .clk        (CLK),
    .srst       (SRST),
    .ext_select (ext_timing),
    .pin_in     (IRQ_PIN_ONE_IN),
    .tick       (base_tick)
  );

  // register writes
  always @(posedge CLK) begin
    if (SRST) begin
      power_mode_control_reg   <= `POWER_MODE_RESET;
      force_check_control_reg  <= `FORCE_CHECK_RESET;
      motion_detect_config_reg <= `MOTION_CFG_RESET;
      irq_map_one_reg          <= `IRQ_MAP_RESET;
      irq_map_two_reg          <= `IRQ_MAP_RESET;
    end else if (WR) begin
      case (ADDR)
        `POWER_MODE_OFFSET: begin
          // reserved codes are stored as written; behaviour then undefined
          power_mode_control_reg <= WDATA;
        end
        `FORCE_CHECK_OFFSET: begin
          force_check_control_reg <= WDATA;
        end
        `MOTION_CFG_OFFSET: begin
          motion_detect_config_reg <= WDATA;
        end
        `IRQ_MAP_ONE_OFFSET: begin
          irq_map_one_reg <= WDATA;
        end
        `IRQ_MAP_TWO_OFFSET: begin
          irq_map_two_reg <= WDATA;
        end
        default: begin
          power_mode_control_reg <= power_mode_control_reg;
        end
      endcase
    end
  end

  // read mux, answered the cycle after the strobe
  always @* begin
    case (ADDR)
      `POWER_MODE_OFFSET:  read_next = power_mode_control_reg;
      `FORCE_CHECK_OFFSET: read_next = force_check_control_reg;
      `MOTION_CFG_OFFSET:  read_next = motion_detect_config_reg;
      `IRQ_MAP_ONE_OFFSET: read_next = irq_map_one_reg;
      `IRQ_MAP_TWO_OFFSET: read_next = irq_map_two_reg;
      default:             read_next = `UNMAPPED_READ;
    endcase
  end

  always @(posedge CLK) begin
    if (SRST) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      RDATA <= read_next;
    end else begin
      RDATA <= 8'h00;
    end
  end

  // awake state: activity wins over inactivity in the same cycle
  always @* begin
    awake_next = awake_reg;
    if (!measuring || !link_loop) begin
      awake_next = 1'b1;
    end else if (ACTIVITY_EVENT) begin
      awake_next = 1'b1;
    end else if (INACTIVITY_EVENT) begin
      awake_next = 1'b0;
    end
  end

  always @(posedge CLK) begin
    if (SRST) begin
      awake_reg <= 1'b1;
    end else begin
      awake_reg <= awake_next;
    end
  end

  // sample strobe: every base tick, or every nth in wake-up mode
  always @(posedge CLK) begin
    if (SRST) begin
      watch_div_reg <= 5'h00;
      SAMPLE_STROBE <= 1'b0;
    end else begin
      SAMPLE_STROBE <= 1'b0;
      if (!measuring) begin
        watch_div_reg <= 5'h00;
      end else if (base_tick) begin
        if (!watch_eff) begin
          watch_div_reg <= 5'h00;
          SAMPLE_STROBE <= 1'b1;
        end else if (watch_div_reg == WATCH_LAST[4:0]) begin
          watch_div_reg <= 5'h00;
          SAMPLE_STROBE <= 1'b1;
        end else begin
          watch_div_reg <= watch_div_reg + 5'h01;
        end
      end
    end
  end

  // registered status and pin outputs
  always @(posedge CLK) begin
    if (SRST) begin
      NOISE_MODE      <= `NOISE_NORMAL;
      RUN_ACTIVE      <= 1'b0;
      WATCH_ACTIVE    <= 1'b0;
      TEST_FORCE      <= 1'b0;
      AWAKE           <= 1'b1;
      IRQ_PIN_ONE_OUT <= 1'b0;
      IRQ_PIN_ONE_OE  <= 1'b0;
      IRQ_PIN_TWO_OUT <= 1'b0;
      IRQ_PIN_TWO_OE  <= 1'b0;
    end else begin
      NOISE_MODE   <= power_mode_control_reg[`NOISE_HI:`NOISE_LO];
      RUN_ACTIVE   <= measuring;
      WATCH_ACTIVE <= measuring & watch_eff;
      TEST_FORCE   <= force_check_control_reg[`TEST_FORCE_BIT];
      AWAKE        <= awake_reg;
      // pin one is an input while it carries the outside clock
      IRQ_PIN_ONE_OE  <= pin_mapped(irq_map_one_reg) & ~ext_timing;
      IRQ_PIN_ONE_OUT <= pin_level(irq_map_one_reg, awake_reg,
                                   INACTIVITY_EVENT, ACTIVITY_EVENT);
      // driven continuously from state, no host traffic needed
      IRQ_PIN_TWO_OE  <= pin_mapped(irq_map_two_reg);
      IRQ_PIN_TWO_OUT <= pin_level(irq_map_two_reg, awake_reg,
                                   INACTIVITY_EVENT, ACTIVITY_EVENT);
    end
  end

endmodule // accel_power_mode_control
`default_nettype wire

// ---- accel_power_mode_control_monitor.sv ----
// Purpose: port checker for the power mode bank
// Assumes: derived outputs follow a write by two edges
// Notes: bound at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module accel_power_mode_control_monitor (
  input wire logic       CLK,
  input wire logic       SRST,
  input wire logic [5:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  input wire logic       ACTIVITY_EVENT,
  input wire logic       INACTIVITY_EVENT,
  input wire logic       IRQ_PIN_ONE_IN,
  input wire logic       IRQ_PIN_ONE_OUT,
  input wire logic       IRQ_PIN_ONE_OE,
  input wire logic       IRQ_PIN_TWO_OUT,
  input wire logic       IRQ_PIN_TWO_OE,
  input wire logic       SAMPLE_STROBE,
  input wire logic [1:0] NOISE_MODE,
  input wire logic       RUN_ACTIVE,
  input wire logic       WATCH_ACTIVE,
  input wire logic       TEST_FORCE,
  input wire logic       AWAKE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  a_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data outside its slot");
  a_run_decode: assert property ($past(WR, 2) && $past(ADDR, 2) == 6'h2d |->
    RUN_ACTIVE == (($past(WDATA, 2) & 8'h03) == 8'h02)) else $error("run decode wrong");
  a_noise_copy: assert property ($past(WR, 2) && $past(ADDR, 2) == 6'h2d |->
    {6'h00, NOISE_MODE} == (($past(WDATA, 2) >> 4) & 8'h03)) else $error("noise wrong");
  a_force_copy: assert property ($past(WR, 2) && $past(ADDR, 2) == 6'h2e |->
    TEST_FORCE == $past(WDATA[0], 2)) else $error("test force wrong");
  a_st_store: assert property (WR && ADDR == 6'h2e ##1 !WR ##1 RD && ADDR == 6'h2e
    |=> RDATA == $past(WDATA, 3)) else $error("self-test readback wrong");
  a_standby_quiet: assert property (!RUN_ACTIVE [*3] |-> !SAMPLE_STROBE)
    else $error("strobe in standby");
  a_awake_idle: assert property (!RUN_ACTIVE [*3] |-> AWAKE)
    else $error("awake low outside measurement");
  a_act_wakes: assert property (ACTIVITY_EVENT |-> ##2 AWAKE)
    else $error("activity did not wake");
  a_ext_pin: assert property (WR && ADDR == 6'h2d && WDATA[6] |-> ##2 !IRQ_PIN_ONE_OE)
    else $error("pin one driven as clock input");
  a_strobe_pulse: assert property (SAMPLE_STROBE |=> !SAMPLE_STROBE)
    else $error("strobe longer than one cycle");
  cover property (INACTIVITY_EVENT ##2 !AWAKE);
  cover property (SAMPLE_STROBE && WATCH_ACTIVE);
  cover property (RD ##1 RDATA != 8'h00);
  cover property (IRQ_PIN_ONE_OE ##1 !IRQ_PIN_ONE_OE);
endmodule // accel_power_mode_control_monitor
bind accel_power_mode_control accel_power_mode_control_monitor mon (.*);
`default_nettype wire

// ---- accel_host_model.sv ----
// Purpose: host side: register master and outside clock source
// Assumes: strobes launched right after a rising edge
// Notes: outside clock stands low while ext_run is low
`timescale 1ns/1ps
`default_nettype none
module accel_host_model (
  input  wire logic       clk,
  input  wire logic       ext_run,
  input  wire logic [7:0] rdata,
  output var  logic [5:0] addr,
  output var  logic [7:0] wdata,
  output var  logic       wr,
  output var  logic       rd,
  output var  logic       external_timebase_select
);
  initial begin
    addr = 6'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  // forty system periods, toggling on falling clk edges
  initial begin
    external_timebase_select = 1'b0;
    forever #160 external_timebase_select = ext_run ? ~external_timebase_select : 1'b0;
  end
  task automatic write_reg(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic read_reg(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // map order, power control last
  task automatic motion_switch;
    write_reg(6'h20, 8'hfa);
    write_reg(6'h21, 8'h00);
    write_reg(6'h22, 8'h02);
    write_reg(6'h23, 8'h96);
    write_reg(6'h24, 8'h00);
    write_reg(6'h25, 8'h1e);
    write_reg(6'h27, 8'h3f);
    write_reg(6'h2b, 8'h40);
    write_reg(6'h2d, 8'h0a);
  endtask
endmodule // accel_host_model
`default_nettype wire

// ---- accel_power_mode_control_tb.sv ----
// Purpose: bench for the power mode bank
// Assumes: host model owns the register port
// Notes: strobe windows span whole tick periods
`timescale 1ns/1ps
`default_nettype none
module accel_power_mode_control_tb;
  logic clk = 0, srst = 1, act = 0, inact = 0, ext_run = 0;
  wire [5:0] addr;
  wire [7:0] wdata, rdata;
  wire [1:0] noise;
  wire wr, rd, xc, p1, p1o, p1e, p2o, p2e, stb, run, watch, tf, awake;
  int err_total = 0, checked = 0, cyc = 0;
  assign p1 = p1e ? p1o : xc;
  accel_host_model h (.clk(clk), .ext_run(ext_run), .rdata(rdata), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .external_timebase_select(xc));
  accel_power_mode_control dut (.CLK(clk), .SRST(srst), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .ACTIVITY_EVENT(act), .INACTIVITY_EVENT(inact),
    .IRQ_PIN_ONE_IN(p1), .IRQ_PIN_ONE_OUT(p1o), .IRQ_PIN_ONE_OE(p1e),
    .IRQ_PIN_TWO_OUT(p2o), .IRQ_PIN_TWO_OE(p2e), .SAMPLE_STROBE(stb),
    .NOISE_MODE(noise), .RUN_ACTIVE(run), .WATCH_ACTIVE(watch), .TEST_FORCE(tf),
    .AWAKE(awake));
  initial forever #4 clk = ~clk;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      print_verdict;
    end
  end
  task settle;
    @(posedge clk);
    #1;
  endtask
  // four-state sum, so an unknown strobe spoils the count
  task automatic count(input int n, output logic [7:0] c);
    c = 8'h00;
    repeat (n) begin
      settle;
      c = c + {7'h00, stb};
    end
  endtask
  task automatic ev(input logic a, input logic i);
    @(posedge clk);
    act <= a;
    inact <= i;
    @(posedge clk);
    act <= 1'b0;
    inact <= 1'b0;
    settle;
  endtask
  task automatic t_regs;
    logic [7:0] d;
    h.read_reg(6'h2d, d);
    chk(d, 8'h00);
    chk({6'h00, run, awake}, 8'h01);
    h.write_reg(6'h2e, 8'ha5);
    h.read_reg(6'h2e, d);
    chk(d, 8'ha5);
    chk({7'h00, tf}, 8'h01);
    h.write_reg(6'h3f, 8'h5a);
    h.read_reg(6'h3f, d);
    chk(d, 8'h00);
    for (int i = 0; i < 3; i++) begin
      h.write_reg(6'h2d, {2'b00, i[1:0], 4'h2});
      settle;
      chk({5'h00, noise, run}, {5'h00, i[1:0], 1'b1});
    end
    $display("register test over");
  endtask
  task automatic t_strobe;
    logic [7:0] c;
    count(1000, c);
    chk(c, 8'h08);
    h.write_reg(6'h2d, 8'h0a);
    count(130, c);
    count(4000, c);
    chk(c, 8'h02);
    ext_run <= 1'b1;
    h.write_reg(6'h2d, 8'h42);
    count(130, c);
    count(400, c);
    chk(c, 8'h0a);
    ext_run <= 1'b0;
    h.write_reg(6'h2d, 8'h00);
    count(130, c);
    chk(c, 8'h00);
    $display("strobe test over");
  endtask
  task automatic t_switch;
    h.motion_switch;
    settle;
    chk({5'h00, watch, p2e, p2o}, 8'h07);
    ev(1'b0, 1'b1);
    chk({6'h00, awake, p2o}, 8'h00);
    ev(1'b1, 1'b0);
    chk({6'h00, awake, p2o}, 8'h03);
    h.write_reg(6'h2b, 8'hc0);
    settle;
    chk({6'h00, p2e, p2o}, 8'h02);
    h.write_reg(6'h2d, 8'h06);
    ev(1'b0, 1'b1);
    chk({7'h00, watch}, 8'h01);
    ev(1'b1, 1'b0);
    chk({7'h00, watch}, 8'h00);
    h.write_reg(6'h27, 8'h00);
    ev(1'b0, 1'b1);
    chk({6'h00, awake, watch}, 8'h02);
    $display("switch test over");
  endtask
  // pin one: event mapping, pulse width, released when it carries the timebase
  task automatic t_pins;
    h.write_reg(6'h2a, 8'h30);
    settle;
    chk({6'h00, p1e, p1o}, 8'h02);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      act <= (k == 0);
      inact <= (k == 1);
      @(posedge clk);
      act <= 1'b0;
      inact <= 1'b0;
      #1;
      chk({7'h00, p1o}, 8'h01);
      settle;
      chk({7'h00, p1o}, 8'h00);
    end
    h.write_reg(6'h2d, 8'h40);
    settle;
    chk({6'h00, p1e, run}, 8'h00);
    h.write_reg(6'h2d, 8'h00);
    $display("pin test over");
  endtask
  // reset in standby with force and both maps set, power control already cleared
  task automatic t_reset;
    logic [7:0] d;
    @(posedge clk);
    srst <= 1'b1;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    h.read_reg(6'h2d, d);
    chk(d, 8'h00);
    h.read_reg(6'h2e, d);
    chk(d, 8'h00);
    chk({1'b0, noise, run, watch, tf, awake, p2e}, 8'h02);
    chk({6'h00, p1e, p2o}, 8'h00);
    $display("reset test over");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    t_regs;
    t_strobe;
    t_switch;
    t_pins;
    t_reset;
    print_verdict;
  end
endmodule // accel_power_mode_control_tb
`default_nettype wire
